// ===== sfr_defines.vh
// Purpose: Constants of the serial flash read front end
// Assumes: Included by the read front end only; the memory and buffer files do not include it
// Notes: Opcodes, lane codes, phase lengths and reset values
//
// Behaviour
// [R01] Opcode 03h reads with three or four address bytes; 13h takes four.
// [R02] Shift in 24 or 32 address bits; decode only A23..A0.
// [R03] Normal read ignores serial input after the last address bit.
// [R04] Single-line data goes out MSB first; address then increments.
// [R05] Address counter wraps from the top location to zero.
// [R06] Host may end a read anytime by raising chip select.
// [R07] Reads arriving while a write is in progress are ignored.
// [R08] Fast read 0Bh three or four bytes, 0Ch four; 8 dummy default.
// [R09] Single fast read samples opcode, address, dummy on rising edges.
// [R10] Single fast read drives data on falling edges.
// [R11] Quad-peripheral fast read: 2 opcode, 6/8 address, 6 dummy clocks.
// [R12] Quad framing also for EBh, 4Bh, 68h; 4Bh and 68h three-byte only.
// [R13] Pause input low with clock low freezes state, floats output.
// [R14] Pause released with clock low; clocks during pause do nothing.
// [R15] Pause unavailable in double rate, quad enable or reset-pin use.
// [R16] Dual reads BBh, BCh take address two bits per clock; 4 dummy.
// [R17] Dual read drives two bits per falling edge, MSB on line 1.
// [R18] First four clocks after dual address carry mode byte; upper nibble used.
// [R19] Upper nibble 1010 enters continuous read; next read skips opcode.
// [R20] Other nibble leaves continuous read; peripheral mode kept.
// [R21] Dummy count includes mode clocks; with 4, data follows mode byte.
// [R22] Chip select high abandons partial instruction; await opcode or address.
// [R23] Host releases data lines after mode bits to avoid contention.
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH

`define SFR_OP_NORMAL_READ 8'h03
`define SFR_OP_NORMAL_READ_WIDE 8'h13
`define SFR_OP_FAST_READ 8'h0B
`define SFR_OP_FAST_READ_WIDE 8'h0C
`define SFR_OP_DUAL_IO_READ 8'hBB
`define SFR_OP_DUAL_IO_READ_WIDE 8'hBC
`define SFR_OP_QUAD_IO_READ 8'hEB
`define SFR_OP_UNIQUE_ID_READ 8'h4B
`define SFR_OP_INFO_ROW_READ 8'h68

`define SFR_DUMMY_FAST 4'h8
`define SFR_DUMMY_QUAD 4'h6
`define SFR_DUMMY_DUAL 4'h4
`define SFR_MODE_CLKS 6'h04
`define SFR_CONT_NIBBLE 4'hA

`define SFR_LW_SINGLE 2'h0
`define SFR_LW_DUAL 2'h1
`define SFR_LW_QUAD 2'h2

`define SFR_CLS_NORMAL 2'h0
`define SFR_CLS_FAST 2'h1
`define SFR_CLS_DUAL 2'h2

`define SFR_OPC_BITS 6'h08
`define SFR_ADDR_BITS_NARROW 6'h18
`define SFR_ADDR_BITS_WIDE 6'h20
`define SFR_ADDR_RST 24'h000000
`define SFR_FILL_BYTE 8'hFF

`endif

// ===== sfr_mem.v
// Purpose: Byte array holding the flash contents
// Assumes: One write port for preload, one registered read port
// Notes: Read data appear one clock after the read strobe
`timescale 1ns/10ps
module sfr_mem #(
  parameter AW = 10
) (
  input wire i_ref_clk,
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_addr,
  input wire [7:0] i_wr_data,
  input wire i_rd_en,
  input wire [AW-1:0] i_rd_addr,
  output reg [7:0] o_rd_data
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule

// ===== sfr_buf.v
// Purpose: Two-entry buffer between array fetch and output shifter
// Assumes: Flush clears both entries in one clock
// Notes: Full and empty are exact; push is refused while full
`timescale 1ns/10ps
module sfr_buf #(
  parameter W = 8
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] ent_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data = ent_q[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always @(posedge i_ref_clk) begin
    if (push) begin
      ent_q[wr_q] <= i_in_data;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (i_flush) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

// ===== sfr_read.v
// Purpose: Read-command front end of a serial flash, oversampling the bus
// Assumes: Serial clock well below a quarter of i_ref_clk
// Notes: Config and status ports are on the i_ref_clk domain
`timescale 1ns/10ps
`include "sfr_defines.vh"
module sfr_read #(
  parameter MEM_AW = 10
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_sck,
  input wire i_cs_n,
  input wire i_hold_n,
  input wire [3:0] i_io_in,
  output reg [3:0] o_io_out,
  output reg [3:0] o_io_oe,
  input wire i_extended_address_flag,
  input wire i_write_in_progress_flag,
  input wire i_quad_peripheral_mode,
  input wire i_quad_enable_bit,
  input wire i_dtr_mode,
  input wire i_hold_pin_is_reset,
  input wire [3:0] i_dummy_cfg,
  input wire i_load_en,
  input wire [MEM_AW-1:0] i_load_addr,
  input wire [7:0] i_load_data,
  output reg o_continuous_read_mode,
  output reg o_read_active,
  output reg o_paused
);
  localparam ST_IDLE = 3'h0;
  localparam ST_OPC = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_MODE = 3'h3;
  localparam ST_DUMMY = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_IGNORE = 3'h6;

  // Shift lane bits into the low end
  function [31:0] shift_in;
    input [31:0] sh;
    input [3:0] io;
    input [1:0] lw;
    begin
      case (lw)
        `SFR_LW_DUAL: shift_in = {sh[29:0], io[1], io[0]};
        `SFR_LW_QUAD: shift_in = {sh[27:0], io};
        default: shift_in = {sh[30:0], io[0]};
      endcase
    end
  endfunction

  // Map the top bits of a byte onto the lanes
  function [3:0] lane_out;
    input [7:0] b;
    input [1:0] lw;
    begin
      case (lw)
        `SFR_LW_DUAL: lane_out = {2'b00, b[7], b[6]};
        `SFR_LW_QUAD: lane_out = b[7:4];
        default: lane_out = {2'b00, b[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] lane_oe;
    input [1:0] lw;
    begin
      case (lw)
        `SFR_LW_DUAL: lane_oe = 4'h3;
        `SFR_LW_QUAD: lane_oe = 4'hF;
        default: lane_oe = 4'h2;
      endcase
    end
  endfunction

  // Clocks needed for a number of bits on the given lanes
  function [5:0] phase_clks;
    input [5:0] bits;
    input [1:0] lw;
    begin
      phase_clks = bits >> lw;
    end
  endfunction

  // Opcode decode: {valid, class[1:0], lanes[1:0], wide}
  function [5:0] decode;
    input [7:0] op;
    input qpm;
    input ext;
    begin
      decode = 6'h00;
      if (qpm) begin
        case (op)
          `SFR_OP_FAST_READ: decode = {1'b1, `SFR_CLS_FAST, `SFR_LW_QUAD, ext}; // [R11]
          `SFR_OP_FAST_READ_WIDE: decode = {1'b1, `SFR_CLS_FAST, `SFR_LW_QUAD, 1'b1}; // [R11]
          `SFR_OP_QUAD_IO_READ: decode = {1'b1, `SFR_CLS_FAST, `SFR_LW_QUAD, ext}; // [R12]
          `SFR_OP_UNIQUE_ID_READ: decode = {1'b1, `SFR_CLS_FAST, `SFR_LW_QUAD, 1'b0}; // [R12]
          `SFR_OP_INFO_ROW_READ: decode = {1'b1, `SFR_CLS_FAST, `SFR_LW_QUAD, 1'b0}; // [R12]
          default: decode = 6'h00;
        endcase
      end else begin
        case (op)
          `SFR_OP_NORMAL_READ: decode = {1'b1, `SFR_CLS_NORMAL, `SFR_LW_SINGLE, ext}; // [R01]
          `SFR_OP_NORMAL_READ_WIDE: decode = {1'b1, `SFR_CLS_NORMAL, `SFR_LW_SINGLE, 1'b1}; // [R01]
          `SFR_OP_FAST_READ: decode = {1'b1, `SFR_CLS_FAST, `SFR_LW_SINGLE, ext}; // [R08]
          `SFR_OP_FAST_READ_WIDE: decode = {1'b1, `SFR_CLS_FAST, `SFR_LW_SINGLE, 1'b1}; // [R08]
          `SFR_OP_DUAL_IO_READ: decode = {1'b1, `SFR_CLS_DUAL, `SFR_LW_DUAL, ext}; // [R16]
          `SFR_OP_DUAL_IO_READ_WIDE: decode = {1'b1, `SFR_CLS_DUAL, `SFR_LW_DUAL, 1'b1}; // [R16]
          default: decode = 6'h00;
        endcase
      end
    end
  endfunction

  // Pin synchronisers: s1 feeds only s2
  reg [6:0] pin_s1_q;
  reg [6:0] pin_s2_q;
  reg sck_s3_q;
  wire sck_s;
  wire cs_s;
  wire hold_s;
  wire [3:0] io_s;
  wire rise_ev;
  wire fall_ev;

  reg [2:0] st_q;
  reg [1:0] cls_q;
  reg [1:0] lw_q;
  reg wide_q;
  reg [5:0] cnt_q;
  reg [31:0] sh_q;
  reg [23:0] addr_q;
  reg cont_q;
  reg cont_wide_q;
  reg paused_q;
  reg fetch_en_q;
  reg inflight_q;
  reg driving_q;
  reg [7:0] dsh_q;
  reg [2:0] dleft_q;
  reg [3:0] out_q;

  wire [31:0] sh_nx;
  wire [5:0] dec;
  wire [3:0] dummy_eff;
  wire [3:0] dummy_def;
  wire hold_en;
  wire active;
  wire addr_done;
  wire flush;
  wire issue;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire [7:0] mem_rd_data;
  wire pop;
  wire [7:0] next_byte;
  wire [5:0] addr_bits;

  assign sck_s = pin_s2_q[4];
  assign cs_s = pin_s2_q[5];
  assign hold_s = pin_s2_q[6];
  assign io_s = pin_s2_q[3:0];
  assign rise_ev = sck_s && !sck_s3_q;
  assign fall_ev = !sck_s && sck_s3_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= 7'h60;
      pin_s2_q <= 7'h60;
      sck_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {i_hold_n, i_cs_n, i_sck, i_io_in};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= sck_s;
    end
  end

  assign hold_en = !(i_dtr_mode || i_quad_enable_bit || i_hold_pin_is_reset); // [R15]
  // Edges during a pause never reach the sequencer
  assign active = !cs_s && !paused_q; // [R13] [R14]
  assign sh_nx = shift_in(sh_q, io_s, lw_q); // [R09]
  assign dec = decode(sh_nx[7:0], i_quad_peripheral_mode,
                      i_extended_address_flag);
  assign dummy_def = (cls_q == `SFR_CLS_DUAL) ? `SFR_DUMMY_DUAL :
                     (lw_q == `SFR_LW_QUAD) ? `SFR_DUMMY_QUAD :
                     `SFR_DUMMY_FAST;
  assign dummy_eff = (i_dummy_cfg != 4'h0) ? i_dummy_cfg : dummy_def;
  assign addr_bits = dec[0] ? `SFR_ADDR_BITS_WIDE : `SFR_ADDR_BITS_NARROW;
  assign addr_done = active && rise_ev && (st_q == ST_ADDR) &&
                     (cnt_q == 6'h01);
  assign flush = addr_done || cs_s;
  assign issue = fetch_en_q && !inflight_q && buf_in_ready && !flush;
  assign next_byte = buf_out_valid ? buf_out_data : `SFR_FILL_BYTE;
  assign pop = active && fall_ev && (st_q == ST_DATA) && (dleft_q == 3'h0);

  // Pause entered and released only while the clock is low; deselect or unavailability clears it at any clock level
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      paused_q <= 1'b0;
    end else if (cs_s || !hold_en) begin
      paused_q <= 1'b0; // [R15]
    end else if (!paused_q && !hold_s && !sck_s) begin
      paused_q <= 1'b1; // [R13]
    end else if (paused_q && hold_s && !sck_s) begin
      paused_q <= 1'b0; // [R14]
    end
  end

  // Command sequencer
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      cls_q <= `SFR_CLS_NORMAL;
      lw_q <= `SFR_LW_SINGLE;
      wide_q <= 1'b0;
      cnt_q <= 6'h00;
      sh_q <= 32'h00000000;
      addr_q <= `SFR_ADDR_RST;
      cont_q <= 1'b0;
      cont_wide_q <= 1'b0;
      fetch_en_q <= 1'b0;
    end else if (cs_s) begin
      st_q <= ST_IDLE; // [R06] [R22]
      fetch_en_q <= 1'b0;
    end else begin
      if (issue) begin
        addr_q <= addr_q + 24'h000001; // [R04] [R05]
      end
      case (st_q)
        ST_IDLE: begin
          sh_q <= 32'h00000000;
          if (cont_q) begin
            // Continuous read starts straight at the address
            cls_q <= `SFR_CLS_DUAL; // [R19]
            lw_q <= `SFR_LW_DUAL;
            wide_q <= cont_wide_q;
            cnt_q <= phase_clks(cont_wide_q ? `SFR_ADDR_BITS_WIDE :
                                `SFR_ADDR_BITS_NARROW, `SFR_LW_DUAL);
            st_q <= i_write_in_progress_flag ? ST_IGNORE : ST_ADDR; // [R07]
          end else begin
            lw_q <= i_quad_peripheral_mode ? `SFR_LW_QUAD : `SFR_LW_SINGLE;
            cnt_q <= phase_clks(`SFR_OPC_BITS, i_quad_peripheral_mode ?
                                `SFR_LW_QUAD : `SFR_LW_SINGLE); // [R11]
            st_q <= ST_OPC;
          end
        end
        ST_OPC: begin
          if (active && rise_ev) begin
            sh_q <= sh_nx; // [R09]
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
              if (!dec[5] || i_write_in_progress_flag) begin
                st_q <= ST_IGNORE; // [R07]
              end else begin
                cls_q <= dec[4:3];
                lw_q <= dec[2:1];
                wide_q <= dec[0];
                cnt_q <= phase_clks(addr_bits, dec[2:1]); // [R01] [R16]
                st_q <= ST_ADDR;
              end
            end
          end
        end
        ST_ADDR: begin
          if (active && rise_ev) begin
            sh_q <= sh_nx;
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
              // Upper address byte of a wide address is dropped
              addr_q <= sh_nx[23:0]; // [R02]
              fetch_en_q <= 1'b1;
              if (cls_q == `SFR_CLS_NORMAL) begin
                st_q <= ST_DATA; // [R03]
              end else if (cls_q == `SFR_CLS_DUAL) begin
                cont_wide_q <= wide_q;
                cnt_q <= `SFR_MODE_CLKS; // [R18]
                st_q <= ST_MODE;
              end else if (dummy_eff == 4'h0) begin
                st_q <= ST_DATA;
              end else begin
                cnt_q <= {2'b00, dummy_eff}; // [R08] [R11]
                st_q <= ST_DUMMY;
              end
            end
          end
        end
        ST_MODE: begin
          if (active && rise_ev) begin
            sh_q <= sh_nx;
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
              // Lower nibble of the mode byte is not looked at
              cont_q <= (sh_nx[7:4] == `SFR_CONT_NIBBLE); // [R18] [R19] [R20]
              if ({2'b00, dummy_eff} <= `SFR_MODE_CLKS) begin
                st_q <= ST_DATA; // [R21]
              end else begin
                cnt_q <= {2'b00, dummy_eff} - `SFR_MODE_CLKS; // [R21]
                st_q <= ST_DUMMY;
              end
            end
          end
        end
        ST_DUMMY: begin
          if (active && rise_ev) begin
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
              st_q <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          st_q <= ST_DATA; // [R03]
        end
        ST_IGNORE: begin
          st_q <= ST_IGNORE; // [R07]
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Array fetch with one read in flight
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      inflight_q <= 1'b0;
    end else begin
      inflight_q <= issue;
    end
  end

  sfr_mem #(
    .AW(MEM_AW)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_wr_en(i_load_en),
    .i_wr_addr(i_load_addr),
    .i_wr_data(i_load_data),
    .i_rd_en(issue),
    .i_rd_addr(addr_q[MEM_AW-1:0]),
    .o_rd_data(mem_rd_data)
  );

  sfr_buf #(
    .W(8)
  ) u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_flush(flush),
    .i_in_valid(inflight_q && !flush),
    .o_in_ready(buf_in_ready),
    .i_in_data(mem_rd_data),
    .o_out_valid(buf_out_valid),
    .i_out_ready(pop),
    .o_out_data(buf_out_data)
  );

  // Output shifter, advanced on falling edges
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      driving_q <= 1'b0;
      dsh_q <= 8'h00;
      dleft_q <= 3'h0;
      out_q <= 4'h0;
    end else if (cs_s) begin
      driving_q <= 1'b0; // [R06]
      dleft_q <= 3'h0;
    end else if (active && fall_ev && (st_q == ST_DATA)) begin
      driving_q <= 1'b1;
      if (dleft_q == 3'h0) begin
        out_q <= lane_out(next_byte, lw_q); // [R04] [R10] [R17]
        dsh_q <= next_byte << (3'h1 << lw_q);
        dleft_q <= 3'h7 >> lw_q;
      end else begin
        out_q <= lane_out(dsh_q, lw_q); // [R04] [R17]
        dsh_q <= dsh_q << (3'h1 << lw_q);
        dleft_q <= dleft_q - 3'h1;
      end
    end
  end

  // Registered pins and status
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_io_out <= 4'h0;
      o_io_oe <= 4'h0;
      o_continuous_read_mode <= 1'b0;
      o_read_active <= 1'b0;
      o_paused <= 1'b0;
    end else begin
      o_io_out <= out_q;
      o_io_oe <= (driving_q && active) ? lane_oe(lw_q) : 4'h0; // [R13]
      o_continuous_read_mode <= cont_q;
      o_read_active <= !cs_s && (st_q >= ST_ADDR) && (st_q <= ST_DATA);
      o_paused <= paused_q;
    end
  end
endmodule

// ===== sfr_read_props.sv
// Purpose: Port-level checks on the serial flash read front end
// Assumes: Mode and flag inputs change only between transfers
// Notes: Bound to every sfr_read instance
`timescale 1ns/10ps
module sfr_read_props (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_sck,
  input wire i_cs_n,
  input wire i_write_in_progress_flag,
  input wire i_quad_peripheral_mode,
  input wire i_quad_enable_bit,
  input wire i_dtr_mode,
  input wire i_hold_pin_is_reset,
  input wire [3:0] o_io_out,
  input wire [3:0] o_io_oe,
  input wire o_continuous_read_mode,
  input wire o_read_active,
  input wire o_paused
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  property p_oe_code;
    o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF};
  endproperty
  a_oe_code: assert property (p_oe_code)
    else $error("illegal output enable pattern");
  property p_cs_off;
    $rose(i_cs_n) |-> ##[1:8] (o_io_oe == 4'h0);
  endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("output still driven after deselect");
  property p_cs_idle;
    $rose(i_cs_n) |-> ##[1:8] !o_read_active;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("read still active after deselect");
  property p_wip;
    $rose(o_read_active) |-> !i_write_in_progress_flag;
  endproperty
  a_wip: assert property (p_wip)
    else $error("read started during write in progress");
  property p_pause_float;
    o_paused |-> o_io_oe == 4'h0;
  endproperty
  a_pause_float: assert property (p_pause_float)
    else $error("output driven while paused");
  property p_no_pause;
    (i_quad_enable_bit || i_dtr_mode || i_hold_pin_is_reset) [*2]
      |-> !o_paused;
  endproperty
  a_no_pause: assert property (p_no_pause)
    else $error("pause taken while unavailable");
  property p_cont_sel;
    $changed(o_continuous_read_mode) |-> !i_cs_n;
  endproperty
  a_cont_sel: assert property (p_cont_sel)
    else $error("continuous mode changed while deselected");
  property p_quad_oe;
    $rose(|o_io_oe) && i_quad_peripheral_mode |-> o_io_oe == 4'hF;
  endproperty
  a_quad_oe: assert property (p_quad_oe)
    else $error("quad data not on four lines");
  property p_oe_active;
    $rose(|o_io_oe) |-> o_read_active;
  endproperty
  a_oe_active: assert property (p_oe_active)
    else $error("output driven outside a read");
  property p_hold_data;
    (i_sck && !i_cs_n) [*3] |-> $stable(o_io_out);
  endproperty
  a_hold_data: assert property (p_hold_data)
    else $error("data changed while serial clock high");
  c_pause: cover property ($rose(o_paused));
  c_cont: cover property ($rose(o_continuous_read_mode));
  c_quad: cover property ($rose(o_io_oe == 4'hF));
endmodule
bind sfr_read sfr_read_props props_u (.i_ref_clk(i_ref_clk),
  .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .i_write_in_progress_flag(i_write_in_progress_flag),
  .i_quad_peripheral_mode(i_quad_peripheral_mode),
  .i_quad_enable_bit(i_quad_enable_bit), .i_dtr_mode(i_dtr_mode),
  .i_hold_pin_is_reset(i_hold_pin_is_reset), .o_io_out(o_io_out),
  .o_io_oe(o_io_oe), .o_continuous_read_mode(o_continuous_read_mode),
  .o_read_active(o_read_active), .o_paused(o_paused));

// ===== sfr_host.sv
// Purpose: Host model driving the serial flash read bus
// Assumes: Mode 0 clocking, eight reference clocks per serial clock
// Notes: Lines it does not drive toggle every reference clock
`timescale 1ns/10ps
module sfr_host (
  input wire logic i_ref_clk,
  input wire logic [3:0] i_io,
  output logic o_sck = 1'b0,
  output logic o_cs_n = 1'b1,
  output logic o_hold_n = 1'b1,
  output logic [3:0] o_io,
  output logic [3:0] o_en = 4'h0
);
  logic [3:0] drv_q = 4'h0;
  logic [3:0] junk_q = 4'h5;
  logic [3:0] smp;
  logic [7:0] got_byte;
  event got;
  always @(posedge i_ref_clk) begin
    junk_q <= ~junk_q;
  end
  assign o_io = (o_en & drv_q) | (~o_en & junk_q);
  task automatic half;
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
  // One serial clock: set while low, sample late in the high half
  task automatic cyc(input logic [3:0] v, input logic [3:0] en);
    drv_q = v;
    o_en = en;
    half();
    o_sck = ~o_sck;
    half();
    smp = i_io;
    o_sck = ~o_sck;
  endtask
  task automatic send(input int lw, input logic [31:0] v, input int nb);
    logic [3:0] m;
    m = 4'((1 << lw) - 1);
    for (int i = nb - lw; i >= 0; i -= lw) begin
      cyc(4'(v >> i) & m, m);
    end
  endtask
  task automatic recv(input int lw, input int n);
    logic [7:0] b;
    b = 8'h00;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i += lw) begin
        cyc(4'h0, 4'h0);
        case (lw)
          1: b = {b[6:0], smp[1]};
          2: b = {b[5:0], smp[1:0]};
          default: b = {b[3:0], smp};
        endcase
      end
      got_byte = b;
      ->got;
    end
  endtask
  task automatic sel(input logic on);
    o_cs_n = ~on;
    half();
    half();
  endtask
  task automatic pause(input int n);
    half();
    o_hold_n = 1'b0;
    half();
    repeat (n) begin
      o_sck = ~o_sck;
      half();
      o_sck = ~o_sck;
      half();
    end
  endtask
  task automatic resume;
    o_hold_n = 1'b1;
    half();
  endtask
endmodule

// ===== sfr_tb.sv
// Purpose: Self-checking bench for the serial flash read front end
// Assumes: Host model paces the serial clock at 320 ns
// Notes: Driver queues expected bytes, a monitor compares them
`timescale 1ns/10ps
module tb;
  localparam int AW = 6;
  logic clk, rst, write_in_progress_flag, qpm, ext, qe, dtr, hrst, ld_en;
  logic [3:0] dcfg;
  logic [AW-1:0] ld_a;
  logic [7:0] ld_d, nxt;
  logic [31:0] a;
  logic [7:0] mem [0:(1 << AW) - 1];
  logic [7:0] exp_q [$];
  integer seed = 32'h9815;
  int num_errors = 0;
  int cmp_count = 0;
  wire [3:0] io_w, dout, doe, hio, hen;
  wire sck, cs_n, hold_n, cont, act, paused;
  assign io_w = (doe & dout) | (~doe & hio);
  sfr_read #(.MEM_AW(AW)) dut_u (.i_ref_clk(clk), .i_rst(rst),
    .i_sck(sck), .i_cs_n(cs_n), .i_hold_n(hold_n), .i_io_in(io_w),
    .o_io_out(dout), .o_io_oe(doe), .i_extended_address_flag(ext),
    .i_write_in_progress_flag(write_in_progress_flag), .i_quad_peripheral_mode(qpm),
    .i_quad_enable_bit(qe), .i_dtr_mode(dtr), .i_hold_pin_is_reset(hrst),
    .i_dummy_cfg(dcfg), .i_load_en(ld_en), .i_load_addr(ld_a),
    .i_load_data(ld_d), .o_continuous_read_mode(cont),
    .o_read_active(act), .o_paused(paused));
  sfr_host host_u (.i_ref_clk(clk), .i_io(io_w), .o_sck(sck),
    .o_cs_n(cs_n), .o_hold_n(hold_n), .o_io(hio), .o_en(hen));
  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    cmp_count++;
    if (e !== g) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    cmp_count++;
    if (e !== g) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Full read; opcode 00 means continuous read without opcode
  task automatic rd(input logic [7:0] op, input int alw, input int ab,
                    input int md, input int dm, input int dlw, input int n);
    host_u.sel(1'b1);
    if (op != 8'h00) host_u.send(qpm ? 4 : 1, op, 8);
    host_u.send(alw, a, ab);
    if (md >= 0) host_u.send(2, md, 8);
    repeat (dm) host_u.cyc(4'h0, 4'h0);
    for (int i = 0; i < n; i++) exp_q.push_back(mem[AW'(a + i)]);
    host_u.recv(dlw, n);
    host_u.sel(1'b0);
    a = $random(seed);
  endtask
  always @(host_u.got) begin
    nxt = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
    chk_byte("rd_byte", nxt, host_u.got_byte);
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #3000000;
    num_errors++;
    complete_run();
  end
  initial begin
    {rst, write_in_progress_flag, qpm, ext, qe, dtr, hrst, ld_en} = 8'h80;
    {dcfg, ld_a, ld_d, a} = {4'h0, 6'h00, 8'h00, 32'h0};
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < (1 << AW); i++) begin
      ld_en = 1'b1;
      ld_a = AW'(i);
      ld_d = 8'($random(seed));
      mem[i] = ld_d;
      @(posedge clk);
      #1;
    end
    ld_en = 1'b0;
    rd(8'h03, 1, 24, -1, 0, 1, 3);
    a = 32'hA5FFFFFE;
    rd(8'h13, 1, 32, -1, 0, 1, 4);
    ext = !ext;
    rd(8'h03, 1, 32, -1, 0, 1, 2);
    rd(8'h0B, 1, 32, -1, 8, 1, 2);
    ext = !ext;
    rd(8'h0C, 1, 32, -1, 8, 1, 2);
    rd(8'h0B, 1, 24, -1, 8, 1, 2);
    dcfg = 4'h8 | 4'($random(seed));
    rd(8'h0B, 1, 24, -1, dcfg, 1, 1);
    dcfg = 4'h0;
    $display("test single done");
    qpm = !qpm;
    rd(8'h0B, 4, 24, -1, 6, 4, 2);
    ext = !ext;
    rd(8'h0B, 4, 32, -1, 6, 4, 2);
    rd(8'hEB, 4, 32, -1, 6, 4, 2);
    for (int k = 0; k < 2; k++) begin
      host_u.sel(1'b1);
      host_u.send(4, k ? 8'h68 : 8'h4B, 8);
      host_u.send(4, a, 24);
      repeat (7) host_u.cyc(4'h0, 4'h0);
      chk_flag("quad_oe", 1'b1, doe === 4'hF);
      host_u.sel(1'b0);
    end
    qpm = !qpm;
    ext = !ext;
    $display("test quad done");
    rd(8'hBB, 2, 24, 8'hA5, 0, 2, 2);
    chk_flag("cont", 1'b1, cont);
    rd(8'h00, 2, 24, 8'h35, 0, 2, 2);
    chk_flag("cont", 1'b0, cont);
    rd(8'hBC, 2, 32, 8'h5A, 0, 2, 1);
    $display("test dual done");
    write_in_progress_flag = !write_in_progress_flag;
    host_u.sel(1'b1);
    host_u.send(1, 8'h03, 8);
    host_u.send(1, a, 24);
    repeat (9) host_u.cyc(4'h0, 4'h0);
    chk_flag("oe_off", 1'b1, doe === 4'h0);
    chk_flag("active", 1'b0, act);
    host_u.sel(1'b0);
    write_in_progress_flag = !write_in_progress_flag;
    host_u.sel(1'b1);
    host_u.send(1, 8'h0B, 8);
    host_u.send(1, a, 10);
    host_u.sel(1'b0);
    rd(8'h03, 1, 24, -1, 0, 1, 1);
    $display("test refuse done");
    host_u.sel(1'b1);
    host_u.send(1, 8'h03, 8);
    host_u.send(1, a >> 12, 12);
    host_u.pause(3);
    chk_flag("paused", 1'b1, paused);
    host_u.resume();
    host_u.send(1, a, 12);
    exp_q.push_back(mem[AW'(a)]);
    exp_q.push_back(mem[AW'(a + 1)]);
    host_u.recv(1, 1);
    host_u.pause(2);
    chk_flag("paused_oe", 1'b1, doe === 4'h0);
    host_u.resume();
    host_u.recv(1, 1);
    host_u.sel(1'b0);
    for (int k = 0; k < 3; k++) begin
      qe = (k == 0);
      dtr = (k == 1);
      hrst = (k == 2);
      host_u.sel(1'b1);
      host_u.send(1, 8'h03, 8);
      host_u.pause(1);
      chk_flag("paused", 1'b0, paused);
      host_u.resume();
      host_u.sel(1'b0);
    end
    hrst = !hrst;
    $display("test hold done");
    chk_byte("pending", 8'h00, 8'(exp_q.size()));
    complete_run();
  end
endmodule
